// File: common/rpcsc_pkg.sv
`default_nettype none

package rpcsc_pkg;
	// ==========================================================
	// sizes
	localparam int unsigned NUM_PORTS = 4;
	localparam int unsigned PIX_W     = 10;
	localparam int unsigned LEN_W     = 16;
	localparam int unsigned FLG_W     = 4;
	localparam int unsigned THR_W     = 2;
	localparam int unsigned PACK_W    = 2;
	// ==========================================================
	// register offsets
	localparam logic [7:0] ADDR_PORT_SEL  = 8'h4c;
	localparam logic [7:0] ADDR_MAILBOX   = 8'h79;
	localparam logic [7:0] ADDR_ERR_FLAGS = 8'h7a;
	localparam logic [7:0] ADDR_ERR_COUNT = 8'h7b;
	localparam logic [7:0] ADDR_RAW_CFG   = 8'h7c;
	localparam logic [7:0] ADDR_PASS_CTL  = 8'h7d;
	// ==========================================================
	// reset values and count limit
	localparam logic [7:0] RST_MAILBOX  = 8'h01;
	localparam logic [7:0] RST_RAW_CFG  = 8'h20;
	localparam logic [7:0] RST_ZERO     = 8'h00;
	localparam logic [1:0] RST_PASS_THR = 2'h0;
	localparam logic [7:0] COUNT_MAX    = 8'hff;
	// ==========================================================
	// field positions
	localparam int unsigned FLG_LEN     = 3;
	localparam int unsigned FLG_CKSUM   = 2;
	localparam int unsigned FLG_ECC2    = 1;
	localparam int unsigned FLG_ECC1    = 0;
	localparam int unsigned CFG_PACK    = 6;
	localparam int unsigned CFG_T_PAR   = 5;
	localparam int unsigned CFG_T_LINE  = 4;
	localparam int unsigned CFG_T_FRAME = 3;
	localparam int unsigned CFG_AUTO    = 2;
	localparam int unsigned CFG_LV_SNS  = 1;
	localparam int unsigned CFG_FV_SNS  = 0;
	localparam int unsigned PASS_THR    = 0;
	// ==========================================================
	// types
	typedef enum logic [1:0] {
		PACK_NORMAL = 2'h0,
		PACK_RSVD   = 2'h1,
		PACK_UPPER  = 2'h2,
		PACK_LOWER  = 2'h3
	} rpcsc_pack_t;
	typedef enum logic [1:0] {GT_LEARN, GT_SKIP, GT_RUN} rpcsc_gate_st_t;
	// sense 1 means the pin is low while active
	function automatic logic act_level(input logic raw, input logic sense);
		return raw ^ sense;
	endfunction
endpackage

`default_nettype wire

// File: verif/rpcsc_remote_ser.sv
`timescale 1ns/1ps
`default_nettype none

module rpcsc_remote_ser #(
	parameter int unsigned N = 4
) (
	input  wire logic            clk_i,
	input  wire logic            go_i,
	input  wire logic [1:0]      port_i,
	input  wire logic            lv_sense_i,
	input  wire logic            fv_sense_i,
	output logic      [N-1:0]    lv_o,
	output logic      [N-1:0]    fv_o,
	output logic      [N*10-1:0] pix_o
);
	// ==========================================================
	// frame sequencer
	logic [3:0] cnt_q = 4'h0;
	logic       tog_q = 1'b0;
	logic       fv_act;
	logic       lv_act;

	// one frame: twelve cycles of frame valid, two lines of three
	always_ff @(posedge clk_i) begin
		tog_q <= ~tog_q;
		if (cnt_q != 4'h0 || go_i) begin
			cnt_q <= (cnt_q == 4'hd) ? 4'h0 : cnt_q + 4'h1;
		end
	end
	assign fv_act = (cnt_q >= 4'h1) && (cnt_q <= 4'hc);
	assign lv_act = cnt_q inside {[4'h3:4'h5], [4'h8:4'ha]};

	// ==========================================================
	// pins
	// idle ports rest inactive; pixels wander outside frames so stale data shows
	always_comb begin
		lv_o = {N{lv_sense_i}};
		fv_o = {N{fv_sense_i}};
		pix_o = {N{tog_q ? 10'h155 : 10'h2aa}};
		lv_o[port_i] = lv_act ^ lv_sense_i;
		fv_o[port_i] = fv_act ^ fv_sense_i;
		if (fv_act) begin
			pix_o[port_i*10 +: 10] = 10'h2b6;
		end
	end
endmodule

`default_nettype wire

// File: verif/rx_port_csi_status_config_test.sv
`timescale 1ns/1ps
`default_nettype none

module rx_port_csi_status_config_test;
	// ==========================================================
	// harness
	logic        clk, rst, wr, rd, go, lvs, fvs, hit;
	logic [7:0]  addr, wdata, rdata;
	logic [3:0]  lock, len, cks, e2, e1, par, raw, lvi, fvi, lvo, fvo, pass;
	logic [1:0]  prt;
	logic [39:0] pixi, pixo;
	int          mismatches, n_tests;

	rpcsc_port_bank u_dut (.CLOCK_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
		.REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .REG_HIT_O(hit), .RX_LOCK_I(lock),
		.PKT_LEN_ERR_I(len), .PKT_PAYLOAD_CHECK_FAIL_FLAG_I(cks), .PKT_HEADER_MULTIBIT_FAULT_FLAG_I(e2), .PKT_HEADER_SINGLEBIT_FIXED_FLAG_I(e1),
		.LINK_PAR_ERR_I(par), .RAW10_MODE_I(raw), .LINE_VALID_I(lvi), .FRAME_VALID_I(fvi),
		.PIXEL_I(pixi), .PIXEL_O(pixo), .LINE_VALID_O(lvo), .FRAME_VALID_O(fvo),
		.PORT_PASS_O(pass));
	rpcsc_remote_ser u_far (.clk_i(clk), .go_i(go), .port_i(prt), .lv_sense_i(lvs),
		.fv_sense_i(fvs), .lv_o(lvi), .fv_o(fvi), .pix_o(pixi));

	// ==========================================================
	// helpers
	task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// ev raises a length error on port pe in the very cycle of the read
	task automatic rreg(input logic [7:0] a, input logic [7:0] exp, input logic h = 1'b1,
		input logic ev = 1'b0, input int pe = 0);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		len[pe] <= ev;
		@(posedge clk);
		rd <= 1'b0;
		len <= 4'h0;
		#1;
		chk("read data", {2'b00, exp}, {2'b00, rdata});
		chk("hit", {9'h0, h}, {9'h0, hit});
	endtask
	task automatic pulse(input int k, input int p);
		@(posedge clk);
		case (k)
			3: len[p] <= 1'b1;
			2: cks[p] <= 1'b1;
			1: e2[p] <= 1'b1;
			default: e1[p] <= 1'b1;
		endcase
		@(posedge clk);
		{len, cks, e2, e1} <= 16'h0;
	endtask
	// outputs trail the far side by one cycle
	task automatic frame(input logic pe, input logic late, input logic [7:0] px);
		@(posedge clk);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		tick(5);
		#1;
		chk("frame valid", 10'h1, {9'h0, fvo[prt]});
		chk("line valid", 10'h1, {9'h0, lvo[prt]});
		chk("pixel", {2'b00, px}, {2'b00, pixo[prt*10 +: 8]});
		@(posedge clk);
		par[prt] <= pe;
		@(posedge clk);
		par <= 4'h0;
		tick(3);
		#1;
		chk("late frame valid", {9'h0, late}, {9'h0, fvo[prt]});
		tick(6);
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset();
		rreg(8'h79, 8'h01);
		rreg(8'h7a, 8'h00);
		rreg(8'h7b, 8'h00);
		rreg(8'h7c, 8'h20);
		chk("pass", 10'hf, {6'h0, pass});
	endtask
	task automatic t_ports();
		for (int p = 0; p < 4; p++) begin
			wreg(8'h4c, p[7:0]);
			wreg(8'h79, 8'h40 + p[7:0]);
		end
		for (int p = 0; p < 4; p++) begin
			wreg(8'h4c, p[7:0]);
			rreg(8'h79, 8'h40 + p[7:0]);
		end
	endtask
	task automatic t_flags();
		wreg(8'h4c, 8'h02);
		for (int b = 0; b < 4; b++) begin
			pulse(b, 2);
			rreg(8'h7a, 8'h01 << b);
			rreg(8'h7a, 8'h00);
		end
		pulse(3, 1);
		rreg(8'h7b, 8'h04);
		rreg(8'h7b, 8'h00);
		rreg(8'h7a, 8'h00, 1'b1, 1'b1, 2);
		rreg(8'h7b, 8'h01, 1'b1, 1'b1, 2);
		rreg(8'h7b, 8'h01);
		rreg(8'h7a, 8'h08);
		wreg(8'h4c, 8'h01);
		rreg(8'h7a, 8'h08);
	endtask
	task automatic t_sat();
		wreg(8'h4c, 8'h00);
		@(posedge clk);
		cks[0] <= 1'b1;
		tick(300);
		cks[0] <= 1'b0;
		rreg(8'h7b, 8'hff);
		rreg(8'h7b, 8'h00);
		wreg(8'h7a, 8'hff);
		rreg(8'h7a, 8'h04);
		wreg(8'h7b, 8'h33);
		rreg(8'h7b, 8'h00);
		rreg(8'h80, 8'h00, 1'b0);
	endtask
	task automatic t_video();
		logic [7:0] pk [4];
		pk = '{8'hb6, 8'hb6, 8'had, 8'hb6};
		wreg(8'h4c, 8'h00);
		prt <= 2'h0;
		raw <= 4'h1;
		for (int c = 0; c < 4; c++) begin
			wreg(8'h7c, {c[1:0], 6'h20});
			frame(1'b0, 1'b1, pk[c]);
		end
		lvs <= 1'b1;
		fvs <= 1'b1;
		wreg(8'h7c, 8'h23);
		frame(1'b0, 1'b1, 8'hb6);
		lvs <= 1'b0;
		fvs <= 1'b0;
		wreg(8'h7c, 8'h20);
		frame(1'b1, 1'b0, 8'hb6);
		wreg(8'h7c, 8'h00);
		frame(1'b1, 1'b1, 8'hb6);
	endtask
	task automatic t_thr();
		wreg(8'h7d, 8'h01);
		tick(1);
		#1;
		chk("pass", 10'h0, {9'h0, pass[0]});
		rreg(8'h7d, 8'h01);
		frame(1'b0, 1'b1, 8'hb6);
		#1;
		chk("pass", 10'h1, {9'h0, pass[0]});
	endtask
	// idle levels must be seen while learning, so the frame starts late
	task automatic t_auto();
		wreg(8'h7c, 8'h04);
		tick(4);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		tick(5);
		#1;
		chk("skipped frame valid", 10'h0, {9'h0, fvo[prt]});
		tick(10);
		frame(1'b0, 1'b1, 8'hb6);
	endtask
	task automatic t_pass();
		@(posedge clk);
		lock[3] <= 1'b0;
		tick(3);
		#1;
		chk("pass", 10'h7, {6'h0, pass});
		@(posedge clk);
		lock[3] <= 1'b1;
		tick(3);
		#1;
		chk("pass", 10'hf, {6'h0, pass});
	endtask

	// ==========================================================
	// run
	task automatic close_out();
		$display("comparisons %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// whole run is under a thousand cycles; allow four times that
	initial begin
		#400000;
		mismatches++;
		close_out();
	end
	initial begin
		{rst, wr, rd, go, lvs, fvs} = 6'h20;
		addr = 8'h00;
		wdata = 8'h00;
		prt = 2'h0;
		lock = 4'hf;
		{len, cks, e2, e1, par, raw} = 24'h0;
		mismatches = 0;
		n_tests = 0;
		tick(3);
		rst <= 1'b0;
		t_reset();
		t_ports();
		t_flags();
		t_sat();
		t_video();
		t_thr();
		t_auto();
		t_pass();
		close_out();
	end
endmodule

`default_nettype wire

// File: verilog/rpcsc_port_bank.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Operation
// - port select picks which copy is accessed
// - read/write mailbox byte, resets to one
// - length mismatch sets bit three, read clears
// - payload checksum error sets sticky bit two
// - uncorrected multi-bit header error sets bit one
// - corrected single-bit header error sets bit zero
// - count errored packets, cleared by read
// - raw10 packing: normal, upper, lower, reserved
// - parity error truncates frame when enabled
// - line size change truncates when enabled
// - frame size change truncates, waits threshold
// - auto polarity learns senses, drops one frame
// - otherwise use the two polarity bits
// - line valid sense one means active low
// - frame valid sense one means active low
// - pass after lock and threshold valid frames
module rpcsc_port_bank #(
	parameter int unsigned NUM_PORTS = rpcsc_pkg::NUM_PORTS,
	parameter int unsigned PIX_W     = rpcsc_pkg::PIX_W
) (
	input  wire logic                   CLOCK_I,
	input  wire logic                   RST_I,
	input  wire logic [7:0]             REG_ADDR_I,
	input  wire logic [7:0]             REG_WDATA_I,
	input  wire logic                   REG_WR_I,
	input  wire logic                   REG_RD_I,
	output logic      [7:0]             REG_RDATA_O,
	output logic                        REG_HIT_O,
	input  wire logic [NUM_PORTS-1:0]   RX_LOCK_I,
	input  wire logic [NUM_PORTS-1:0]   PKT_LEN_ERR_I,
	input  wire logic [NUM_PORTS-1:0]   PKT_PAYLOAD_CHECK_FAIL_FLAG_I,
	input  wire logic [NUM_PORTS-1:0]   PKT_HEADER_MULTIBIT_FAULT_FLAG_I,
	input  wire logic [NUM_PORTS-1:0]   PKT_HEADER_SINGLEBIT_FIXED_FLAG_I,
	input  wire logic [NUM_PORTS-1:0]   LINK_PAR_ERR_I,
	input  wire logic [NUM_PORTS-1:0]   RAW10_MODE_I,
	input  wire logic [NUM_PORTS-1:0]   LINE_VALID_I,
	input  wire logic [NUM_PORTS-1:0]   FRAME_VALID_I,
	input  wire logic [NUM_PORTS*PIX_W-1:0] PIXEL_I,
	output logic      [NUM_PORTS*PIX_W-1:0] PIXEL_O,
	output logic      [NUM_PORTS-1:0]   LINE_VALID_O,
	output logic      [NUM_PORTS-1:0]   FRAME_VALID_O,
	output logic      [NUM_PORTS-1:0]   PORT_PASS_O
);
	localparam int unsigned SEL_W = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;
	localparam int unsigned FW    = rpcsc_pkg::FLG_W;
	localparam int unsigned TW    = rpcsc_pkg::THR_W;

	logic [SEL_W-1:0] sel_q, sel_d;
	logic [7:0]       mbox_q  [NUM_PORTS];
	logic [7:0]       mbox_d  [NUM_PORTS];
	logic [FW-1:0]    flags_q [NUM_PORTS];
	logic [FW-1:0]    flags_d [NUM_PORTS];
	logic [7:0]       count_q [NUM_PORTS];
	logic [7:0]       count_d [NUM_PORTS];
	logic [7:0]       cfg_q   [NUM_PORTS];
	logic [7:0]       cfg_d   [NUM_PORTS];
	logic [TW-1:0]    thr_q   [NUM_PORTS];
	logic [TW-1:0]    thr_d   [NUM_PORTS];
	logic [PIX_W-1:0] pix_d   [NUM_PORTS];
	logic [7:0]       rdata_d;
	logic             hit_d;

	// ==========================================================
	// helpers
	function automatic logic acc(input logic en, input logic [7:0] a, input logic [7:0] t);
		return en && (a == t);
	endfunction

	function automatic logic [7:0] sat_inc(input logic [7:0] v);
		return (v == rpcsc_pkg::COUNT_MAX) ? v : v + 8'h01;
	endfunction

	// reserved pack code falls back to plain 10-bit handling
	function automatic logic [PIX_W-1:0] pack_pix(
		input logic             raw10,
		input logic [1:0]       code,
		input logic [PIX_W-1:0] pix
	);
		logic [PIX_W-1:0] r;
		r = pix;
		if (raw10) begin
			case (rpcsc_pkg::rpcsc_pack_t'(code))
				rpcsc_pkg::PACK_UPPER: r = PIX_W'(pix[PIX_W-1 -: 8]);
				rpcsc_pkg::PACK_LOWER: r = PIX_W'(pix[7:0]);
				default:               r = pix;
			endcase
		end
		return r;
	endfunction

	// ==========================================================
	// register state
	always_comb begin
		logic own;
		logic [FW-1:0] ev;
		own = 1'b0;
		ev = '0;
		sel_d = sel_q;
		if (acc(REG_WR_I, REG_ADDR_I, rpcsc_pkg::ADDR_PORT_SEL)) begin
			sel_d = REG_WDATA_I[SEL_W-1:0];
		end
		for (int p = 0; p < NUM_PORTS; p++) begin
			own = (sel_q == SEL_W'(p));
			ev[rpcsc_pkg::FLG_LEN]   = PKT_LEN_ERR_I[p];
			ev[rpcsc_pkg::FLG_CKSUM] = PKT_PAYLOAD_CHECK_FAIL_FLAG_I[p];
			ev[rpcsc_pkg::FLG_ECC2]  = PKT_HEADER_MULTIBIT_FAULT_FLAG_I[p];
			ev[rpcsc_pkg::FLG_ECC1]  = PKT_HEADER_SINGLEBIT_FIXED_FLAG_I[p];
			mbox_d[p] = mbox_q[p];
			if (own && acc(REG_WR_I, REG_ADDR_I, rpcsc_pkg::ADDR_MAILBOX)) begin
				mbox_d[p] = REG_WDATA_I;
			end
			flags_d[p] = flags_q[p];
			if (own && acc(REG_RD_I, REG_ADDR_I, rpcsc_pkg::ADDR_ERR_FLAGS)) begin
				flags_d[p] = '0;
			end
			// set after clear so a same-cycle event survives
			flags_d[p] = flags_d[p] | ev;
			count_d[p] = count_q[p];
			if (own && acc(REG_RD_I, REG_ADDR_I, rpcsc_pkg::ADDR_ERR_COUNT)) begin
				count_d[p] = '0;
			end
			if (|ev) begin
				count_d[p] = sat_inc(count_d[p]);
			end
			cfg_d[p] = cfg_q[p];
			if (own && acc(REG_WR_I, REG_ADDR_I, rpcsc_pkg::ADDR_RAW_CFG)) begin
				cfg_d[p] = REG_WDATA_I;
			end
			thr_d[p] = thr_q[p];
			if (own && acc(REG_WR_I, REG_ADDR_I, rpcsc_pkg::ADDR_PASS_CTL)) begin
				thr_d[p] = REG_WDATA_I[rpcsc_pkg::PASS_THR +: TW];
			end
			pix_d[p] = pack_pix(RAW10_MODE_I[p], cfg_q[p][rpcsc_pkg::CFG_PACK +: 2],
				PIXEL_I[p*PIX_W +: PIX_W]);
		end
	end

	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			sel_q <= '0;
			for (int p = 0; p < NUM_PORTS; p++) begin
				mbox_q[p]  <= rpcsc_pkg::RST_MAILBOX;
				flags_q[p] <= '0;
				count_q[p] <= rpcsc_pkg::RST_ZERO;
				cfg_q[p]   <= rpcsc_pkg::RST_RAW_CFG;
				thr_q[p]   <= rpcsc_pkg::RST_PASS_THR;
				PIXEL_O[p*PIX_W +: PIX_W] <= '0;
			end
		end else begin
			sel_q <= sel_d;
			for (int p = 0; p < NUM_PORTS; p++) begin
				mbox_q[p]  <= mbox_d[p];
				flags_q[p] <= flags_d[p];
				count_q[p] <= count_d[p];
				cfg_q[p]   <= cfg_d[p];
				thr_q[p]   <= thr_d[p];
				PIXEL_O[p*PIX_W +: PIX_W] <= pix_d[p];
			end
		end
	end

	// ==========================================================
	// read path
	always_comb begin
		rdata_d = REG_RDATA_O;
		hit_d = 1'b0;
		if (REG_RD_I || REG_WR_I) begin
			hit_d = 1'b1;
			case (REG_ADDR_I)
				rpcsc_pkg::ADDR_PORT_SEL:  rdata_d = 8'(sel_q);
				rpcsc_pkg::ADDR_MAILBOX:   rdata_d = mbox_q[sel_q];
				rpcsc_pkg::ADDR_ERR_FLAGS: rdata_d = 8'(flags_q[sel_q]);
				rpcsc_pkg::ADDR_ERR_COUNT: rdata_d = count_q[sel_q];
				rpcsc_pkg::ADDR_RAW_CFG:   rdata_d = cfg_q[sel_q];
				rpcsc_pkg::ADDR_PASS_CTL:  rdata_d = 8'(thr_q[sel_q]);
				default: begin
					rdata_d = rpcsc_pkg::RST_ZERO;
					hit_d = 1'b0;
				end
			endcase
			// a write leaves the last read data in place
			if (!REG_RD_I) begin
				rdata_d = REG_RDATA_O;
			end
		end
	end

	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			REG_RDATA_O <= rpcsc_pkg::RST_ZERO;
			REG_HIT_O <= 1'b0;
		end else begin
			REG_RDATA_O <= rdata_d;
			REG_HIT_O <= hit_d;
		end
	end

	// ==========================================================
	// video gating per port
	for (genvar g = 0; g < NUM_PORTS; g++) begin : g_gate
		rpcsc_video_gate u_gate (
			.clk_i         (CLOCK_I),
			.rst_i         (RST_I),
			.lock_i        (RX_LOCK_I[g]),
			.par_err_i     (LINK_PAR_ERR_I[g]),
			.lv_raw_i      (LINE_VALID_I[g]),
			.fv_raw_i      (FRAME_VALID_I[g]),
			.trunc_par_i   (cfg_q[g][rpcsc_pkg::CFG_T_PAR]),
			.trunc_line_i  (cfg_q[g][rpcsc_pkg::CFG_T_LINE]),
			.trunc_frame_i (cfg_q[g][rpcsc_pkg::CFG_T_FRAME]),
			.auto_pol_i    (cfg_q[g][rpcsc_pkg::CFG_AUTO]),
			.lv_sense_i    (cfg_q[g][rpcsc_pkg::CFG_LV_SNS]),
			.fv_sense_i    (cfg_q[g][rpcsc_pkg::CFG_FV_SNS]),
			.pass_thr_i    (thr_q[g]),
			.lv_o          (LINE_VALID_O[g]),
			.fv_o          (FRAME_VALID_O[g]),
			.pass_o        (PORT_PASS_O[g])
		);
	end

	// ==========================================================
	// checks, port 0 watched for flags, count and packing; mailbox and reserved-bit checks follow the selected port
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (RST_I);

	logic rd_f0, rd_c0;
	assign rd_f0 = REG_RD_I && REG_ADDR_I == rpcsc_pkg::ADDR_ERR_FLAGS && sel_q == '0;
	assign rd_c0 = REG_RD_I && REG_ADDR_I == rpcsc_pkg::ADDR_ERR_COUNT && sel_q == '0;

	property p_route;
		(REG_RD_I && !REG_WR_I && REG_ADDR_I == rpcsc_pkg::ADDR_MAILBOX)
		|=> REG_RDATA_O == mbox_q[$past(sel_q)] && REG_HIT_O;
	endproperty
	a_route: assert property (p_route)
		else $error("mailbox read not from selected port");

	property p_mbx_wr;
		(REG_WR_I && REG_ADDR_I == rpcsc_pkg::ADDR_MAILBOX)
		|=> mbox_q[$past(sel_q)] == $past(REG_WDATA_I);
	endproperty
	a_mbx_wr: assert property (p_mbx_wr)
		else $error("mailbox write lost");

	property p_len_set;
		PKT_LEN_ERR_I[0] |=> flags_q[0][rpcsc_pkg::FLG_LEN];
	endproperty
	a_len_set: assert property (p_len_set)
		else $error("length flag not set");

	property p_cksum_hold;
		(flags_q[0][rpcsc_pkg::FLG_CKSUM] && !rd_f0) |=> flags_q[0][rpcsc_pkg::FLG_CKSUM];
	endproperty
	a_cksum_hold: assert property (p_cksum_hold)
		else $error("checksum flag dropped without read");

	property p_ecc2_clear;
		(rd_f0 && !PKT_HEADER_MULTIBIT_FAULT_FLAG_I[0]) |=> !flags_q[0][rpcsc_pkg::FLG_ECC2];
	endproperty
	a_ecc2_clear: assert property (p_ecc2_clear)
		else $error("multi-bit flag not cleared by read");

	property p_ecc1_seen;
		PKT_HEADER_SINGLEBIT_FIXED_FLAG_I[0] ##1 rd_f0 |=> REG_RDATA_O[rpcsc_pkg::FLG_ECC1];
	endproperty
	a_ecc1_seen: assert property (p_ecc1_seen)
		else $error("single-bit flag not reported");

	property p_cnt_clear;
		(rd_c0 && !PKT_LEN_ERR_I[0] && !PKT_PAYLOAD_CHECK_FAIL_FLAG_I[0] && !PKT_HEADER_MULTIBIT_FAULT_FLAG_I[0]
			&& !PKT_HEADER_SINGLEBIT_FIXED_FLAG_I[0]) |=> count_q[0] == rpcsc_pkg::RST_ZERO;
	endproperty
	a_cnt_clear: assert property (p_cnt_clear)
		else $error("counter not cleared by read");

	property p_cnt_sat;
		(count_q[0] == rpcsc_pkg::COUNT_MAX && !rd_c0) |=> count_q[0] == rpcsc_pkg::COUNT_MAX;
	endproperty
	a_cnt_sat: assert property (p_cnt_sat)
		else $error("counter wrapped");

	property p_keep;
		(rd_f0 && PKT_LEN_ERR_I[0]) |=> flags_q[0][rpcsc_pkg::FLG_LEN];
	endproperty
	a_keep: assert property (p_keep)
		else $error("event lost under read clear");

	property p_rsvd;
		(REG_RD_I && REG_ADDR_I == rpcsc_pkg::ADDR_ERR_FLAGS) |=> REG_RDATA_O[7:FW] == '0;
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved status bits not zero");

	property p_pack;
		(RAW10_MODE_I[0] && cfg_q[0][rpcsc_pkg::CFG_PACK +: 2] == rpcsc_pkg::PACK_UPPER)
		|=> PIXEL_O[PIX_W-1:0] == PIX_W'($past(PIXEL_I[PIX_W-1 -: 8]));
	endproperty
	a_pack: assert property (p_pack)
		else $error("upper byte packing wrong");

	c_clear_race: cover property (rd_f0 && PKT_PAYLOAD_CHECK_FAIL_FLAG_I[0]);
	c_count_full: cover property (count_q[0] == rpcsc_pkg::COUNT_MAX ##1 rd_c0);
endmodule

`default_nettype wire

// File: verilog/rpcsc_video_gate.sv
`timescale 1ns/1ps
`default_nettype none

module rpcsc_video_gate (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       lock_i,
	input  wire logic       par_err_i,
	input  wire logic       lv_raw_i,
	input  wire logic       fv_raw_i,
	input  wire logic       trunc_par_i,
	input  wire logic       trunc_line_i,
	input  wire logic       trunc_frame_i,
	input  wire logic       auto_pol_i,
	input  wire logic       lv_sense_i,
	input  wire logic       fv_sense_i,
	input  wire logic [1:0] pass_thr_i,
	output logic            lv_o,
	output logic            fv_o,
	output logic            pass_o
);
	localparam int unsigned LW = rpcsc_pkg::LEN_W;
	rpcsc_pkg::rpcsc_gate_st_t st_q, st_d;
	logic          lvs_q, lvs_d, fvs_q, fvs_d, auto_q;
	logic          lvp_q, fvp_q, drop_q, drop_d, hold_q, hold_d;
	logic          hlen_q, hlen_d, hlin_q, hlin_d, lv_d, fv_d, pass_d;
	logic [LW-1:0] len_q, len_d, plen_q, plen_d, lin_q, lin_d, plin_q, plin_d;
	logic [1:0]    fcnt_q, fcnt_d;
	logic          lv_a, fv_a, lv_r, lv_f, fv_r, fv_f, line_chg, frame_chg, bad;

	// ==========================================================
	// frame tracking
	always_comb begin
		lv_a = rpcsc_pkg::act_level(lv_raw_i, auto_pol_i ? lvs_q : lv_sense_i);
		fv_a = rpcsc_pkg::act_level(fv_raw_i, auto_pol_i ? fvs_q : fv_sense_i);
		lv_r = lv_a & ~lvp_q;
		lv_f = ~lv_a & lvp_q;
		fv_r = fv_a & ~fvp_q;
		fv_f = ~fv_a & fvp_q;
		st_d = st_q;
		lvs_d = lvs_q;
		fvs_d = fvs_q;
		len_d = lv_r ? LW'(1) : (lv_a ? len_q + LW'(1) : len_q);
		plen_d = plen_q;
		hlen_d = hlen_q;
		lin_d = lv_r ? lin_q + LW'(1) : lin_q;
		plin_d = plin_q;
		hlin_d = hlin_q;
		line_chg = lv_f & hlen_q & (len_q != plen_q);
		frame_chg = hlin_q & ((lv_r & (lin_q == plin_q)) | (fv_f & (lin_q != plin_q)));
		if (lv_f) begin
			plen_d = len_q;
			hlen_d = 1'b1;
		end
		if (fv_f) begin
			plin_d = lin_q;
			hlin_d = 1'b1;
			lin_d = '0;
		end
		bad = (par_err_i & trunc_par_i) | (line_chg & trunc_line_i)
		    | (frame_chg & trunc_frame_i);
		case (st_q)
			rpcsc_pkg::GT_LEARN: begin
				// idle level at lock is taken as the inactive level
				if (!auto_pol_i) begin
					st_d = rpcsc_pkg::GT_RUN;
				end else if (lock_i) begin
					lvs_d = lv_raw_i;
					fvs_d = fv_raw_i;
					st_d = rpcsc_pkg::GT_SKIP;
				end
			end
			rpcsc_pkg::GT_SKIP: begin
				// a whole frame with lines must pass before forwarding
				if (!auto_pol_i || (fv_f && lin_q != '0)) begin
					st_d = rpcsc_pkg::GT_RUN;
				end
			end
			rpcsc_pkg::GT_RUN: begin
				if (auto_pol_i && (!lock_i || !auto_q)) begin
					st_d = rpcsc_pkg::GT_LEARN;
				end
			end
			default: st_d = rpcsc_pkg::GT_LEARN;
		endcase
		drop_d = (drop_q & ~fv_r) | bad;
		fcnt_d = fcnt_q;
		if (fv_f && !drop_q && !bad && st_q == rpcsc_pkg::GT_RUN && fcnt_q < pass_thr_i) begin
			fcnt_d = fcnt_q + 2'h1;
		end
		hold_d = hold_q;
		if (frame_chg && trunc_frame_i) begin
			hold_d = 1'b1;
			fcnt_d = '0;
		end
		if (!lock_i) begin
			fcnt_d = '0;
		end
		pass_d = lock_i & ((pass_thr_i == '0) | (fcnt_d >= pass_thr_i));
		if (pass_d) begin
			hold_d = 1'b0;
		end
		fv_d = fv_a & ~drop_d & ~hold_d & (st_d == rpcsc_pkg::GT_RUN);
		lv_d = lv_a & fv_d;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= rpcsc_pkg::GT_LEARN;
			{lvs_q, fvs_q, auto_q, lvp_q, fvp_q} <= '0;
			{drop_q, hold_q, hlen_q, hlin_q} <= '0;
			{lv_o, fv_o, pass_o} <= '0;
			{len_q, plen_q, lin_q, plin_q} <= '0;
			fcnt_q <= '0;
		end else begin
			st_q <= st_d;
			{lvs_q, fvs_q, auto_q, lvp_q, fvp_q} <= {lvs_d, fvs_d, auto_pol_i, lv_a, fv_a};
			{drop_q, hold_q, hlen_q, hlin_q} <= {drop_d, hold_d, hlen_d, hlin_d};
			{lv_o, fv_o, pass_o} <= {lv_d, fv_d, pass_d};
			{len_q, plen_q, lin_q, plin_q} <= {len_d, plen_d, lin_d, plin_d};
			fcnt_q <= fcnt_d;
		end
	end

	// ==========================================================
	// checks
	property p_par_cut;
		@(posedge clk_i) disable iff (rst_i)
		(par_err_i && trunc_par_i) |=> (!fv_o && !lv_o) [*2];
	endproperty
	a_par_cut: assert property (p_par_cut)
		else $error("parity error did not cut the frame");

	property p_pass_zero;
		@(posedge clk_i) disable iff (rst_i)
		(lock_i && pass_thr_i == 2'h0) |=> pass_o;
	endproperty
	a_pass_zero: assert property (p_pass_zero)
		else $error("pass missing with zero threshold and lock");

	property p_fixed_sense;
		@(posedge clk_i) disable iff (rst_i)
		(!auto_pol_i && st_q == rpcsc_pkg::GT_RUN && !drop_d && !hold_d && fv_raw_i == fv_sense_i)
		|=> !fv_o;
	endproperty
	a_fixed_sense: assert property (p_fixed_sense)
		else $error("frame valid forwarded at inactive level");

	c_auto_run: cover property (@(posedge clk_i) disable iff (rst_i)
		st_q == rpcsc_pkg::GT_SKIP ##1 st_q == rpcsc_pkg::GT_RUN);
endmodule

`default_nettype wire
